// ==== rtl/lmf_fault_regs.sv ====
/*
 fault status register bank of a 12-switch led bypass manager, with avalon-mm slave.
 assumes fault and receive-error inputs are one-cycle pulses synchronous to clk.
*/
// The Avalon-MM slave port was decided locally.
// What this block does
// [R01] crc failure sets link status bit 6
// [R02] sync frame parity error sets bit 5
// [R03] payload parity error sets bit 4
// [R04] sync frame stop error sets bit 3
// [R05] payload stop error sets bit 2
// [R06] payload start error sets bit 1
// [R07] short register readable, write one clears
// [R08] twelve short bits, cleared at reset
// [R09] open register readable, write one clears
// [R10] twelve open bits, cleared at reset
// [R11] line inactivity for watchdog period sets bit 8
// [R12] over sixteen idle bit times sets bit 7
// [R13] serial summary high when any link error
// [R14] open summary high when any open bit
// [R15] short summary high when any short bit
`timescale 1ns/100ps
module lmf_fault_regs #(
   parameter logic [23:0] WDOG_CYC = lmf_pkg::WDOG_CYC_RST
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic [7:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   output logic [31:0] readdata,
   output logic waitrequest,
   input wire logic rx_line,
   input wire logic rx_in_frame,
   input wire lmf_pkg::lmf_rx_err_t rx_err,
   input wire logic [11:0] short_detect,
   input wire logic [11:0] open_detect,
   output logic fail_safe,
   output logic short_fault_summary,
   output logic open_fault_summary,
   output logic serial_err_summary,
   output logic irq
);
   typedef struct packed {
      lmf_pkg::lmf_bus_st_t st;
      logic [31:0] rdata;
      logic [8:0] link_err;
      logic [11:0] per_driver_short_bits;
      logic [11:0] per_driver_open_bits;
      logic [2:0] irq_stat;
      logic [2:0] irq_mask;
      logic [15:0] bit_cyc;
      logic [23:0] wdog_cyc;
      logic line_q;
      logic [23:0] idle_cnt;
      logic fail_safe;
   } lmf_state_t;

   lmf_state_t s_reg;
   lmf_state_t s_next;
   logic rst_meta_n;
   logic rst_sync_n;
   logic wr_answer;
   logic [11:0] short_clr_w;
   logic [11:0] open_clr_w;
   logic [11:0] short_next_w;
   logic [11:0] open_next_w;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] idx);
      hit = (a == idx);
   endfunction

   // a write acts only on the edge at which waitrequest is low, so a clear lands once per transfer
   assign wr_answer = write && (s_reg.st == lmf_pkg::ST_ANSWER);
   assign short_clr_w = (wr_answer && hit(address, lmf_pkg::IDX_SHORT)) ? writedata[11:0] : 12'h000; // [R07]
   assign open_clr_w = (wr_answer && hit(address, lmf_pkg::IDX_OPEN)) ? writedata[11:0] : 12'h000; // [R09]

   // one latch per driver; a detect in the clearing cycle wins so no fault is lost
   genvar g;
   generate
      for (g = 0; g < lmf_pkg::NUM_DRV; g = g + 1) begin : g_drv
         assign short_next_w[g] = short_detect[g] | (s_reg.per_driver_short_bits[g] & ~short_clr_w[g]); // [R08]
         assign open_next_w[g] = open_detect[g] | (s_reg.per_driver_open_bits[g] & ~open_clr_w[g]); // [R10]
      end
   endgenerate

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rst_meta_n <= 1'b0;
         rst_sync_n <= 1'b0;
      end else begin
         rst_meta_n <= 1'b1;
         rst_sync_n <= rst_meta_n;
      end
   end

   always_comb begin
      logic wr_go;
      logic rd_go;
      logic [8:0] link_set;
      logic [8:0] link_clr;
      logic [2:0] irq_set;
      logic [31:0] rd_val;
      logic [24:0] bit_limit;
      wr_go = 1'b0;
      rd_go = 1'b0;
      link_set = '0;
      link_clr = '0;
      irq_set = '0;
      rd_val = '0;
      bit_limit = '0;
      s_next = s_reg;
      if (s_reg.st == lmf_pkg::ST_ANSWER) begin
         s_next.st = lmf_pkg::ST_IDLE;
      end else if (read || write) begin
         s_next.st = lmf_pkg::ST_ANSWER;
      end
      // writes take effect on the answering edge, reads on the first edge, once per transfer
      wr_go = wr_answer;
      rd_go = read && (s_reg.st == lmf_pkg::ST_IDLE);
      // receive error sources
      link_set[lmf_pkg::BIT_CRC] = rx_err.crc_fail_flag; // [R01]
      link_set[lmf_pkg::BIT_SYNC_PAR] = rx_err.sync_parity_fail_flag; // [R02]
      link_set[lmf_pkg::BIT_PL_PAR] = rx_err.payload_parity_fail_flag; // [R03]
      link_set[lmf_pkg::BIT_SYNC_STOP] = rx_err.sync_stop_fail_flag; // [R04]
      link_set[lmf_pkg::BIT_PL_STOP] = rx_err.payload_stopbit_fail_flag; // [R05]
      link_set[lmf_pkg::BIT_START] = rx_err.payload_startbit_fail_flag; // [R06]
      // line activity: any edge restarts both idle measurements
      s_next.line_q = rx_line;
      if (rx_line != s_reg.line_q) begin
         s_next.idle_cnt = '0;
      end else if (s_reg.idle_cnt != 24'hffffff) begin
         s_next.idle_cnt = s_reg.idle_cnt + 24'h000001;
      end
      bit_limit = 25'(s_reg.bit_cyc) * 25'(lmf_pkg::TIMEOUT_BITS);
      // one-shot on crossing, so a silent line does not retrigger every cycle
      if (!rx_in_frame && 25'(s_reg.idle_cnt) == bit_limit + 25'h1) begin
         link_set[lmf_pkg::BIT_TIMEOUT] = 1'b1; // [R12]
         s_next.fail_safe = 1'b1; // [R12]
      end
      if (rx_line != s_reg.line_q) begin
         s_next.fail_safe = 1'b0;
      end
      if (s_reg.wdog_cyc != '0 && s_reg.idle_cnt == s_reg.wdog_cyc) begin
         link_set[lmf_pkg::BIT_WDOG] = 1'b1; // [R11]
      end
      if (wr_go && hit(address, lmf_pkg::IDX_LINK_ERR)) begin
         link_clr = writedata[8:0] & lmf_pkg::LINK_ERR_MASK; // [R11]
      end
      if (wr_go && hit(address, lmf_pkg::IDX_IRQ_MASK)) begin
         s_next.irq_mask = writedata[2:0];
      end
      if (wr_go && hit(address, lmf_pkg::IDX_WDOG_CFG)) begin
         s_next.wdog_cyc = writedata[23:0];
      end
      if (wr_go && hit(address, lmf_pkg::IDX_BIT_CFG)) begin
         s_next.bit_cyc = writedata[15:0];
      end
      // set wins over a clear in the same cycle
      s_next.link_err = (s_reg.link_err & ~link_clr) | link_set;
      s_next.per_driver_short_bits = short_next_w; // [R08]
      s_next.per_driver_open_bits = open_next_w; // [R10]
      irq_set[lmf_pkg::IRQ_LINK] = |link_set;
      irq_set[lmf_pkg::IRQ_SHORT] = |short_detect;
      irq_set[lmf_pkg::IRQ_OPEN] = |open_detect;
      if (rd_go) begin
         case (address)
            lmf_pkg::IDX_LINK_ERR: rd_val = {23'h0, s_reg.link_err};
            lmf_pkg::IDX_SHORT: rd_val = {20'h0, s_reg.per_driver_short_bits}; // [R07]
            lmf_pkg::IDX_OPEN: rd_val = {20'h0, s_reg.per_driver_open_bits}; // [R09]
            lmf_pkg::IDX_TOP_STAT: begin
               rd_val[lmf_pkg::BIT_SERIAL_SUM] = |s_reg.link_err; // [R13]
               rd_val[lmf_pkg::BIT_OPEN_SUM] = |s_reg.per_driver_open_bits; // [R14]
               rd_val[lmf_pkg::BIT_SHORT_SUM] = |s_reg.per_driver_short_bits; // [R15]
            end
            lmf_pkg::IDX_IRQ_STAT: rd_val = {29'h0, s_reg.irq_stat};
            lmf_pkg::IDX_IRQ_MASK: rd_val = {29'h0, s_reg.irq_mask};
            lmf_pkg::IDX_WDOG_CFG: rd_val = {8'h0, s_reg.wdog_cyc};
            lmf_pkg::IDX_BIT_CFG: rd_val = {16'h0, s_reg.bit_cyc};
            default: rd_val = '0;
         endcase
         s_next.rdata = rd_val;
      end
      // read of interrupt status clears it; new events still win
      if (rd_go && hit(address, lmf_pkg::IDX_IRQ_STAT)) begin
         s_next.irq_stat = irq_set;
      end else begin
         s_next.irq_stat = s_reg.irq_stat | irq_set;
      end
   end

   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         s_reg.st <= lmf_pkg::ST_IDLE;
         s_reg.rdata <= '0;
         s_reg.link_err <= lmf_pkg::LINK_RST;
         s_reg.per_driver_short_bits <= lmf_pkg::DRV_RST; // [R08]
         s_reg.per_driver_open_bits <= lmf_pkg::DRV_RST; // [R10]
         s_reg.irq_stat <= '0;
         s_reg.irq_mask <= lmf_pkg::IRQ_MASK_RST;
         s_reg.bit_cyc <= lmf_pkg::BIT_CYC_RST;
         s_reg.wdog_cyc <= WDOG_CYC;
         s_reg.line_q <= 1'b1;
         s_reg.idle_cnt <= '0;
         s_reg.fail_safe <= 1'b0;
      end else begin
         s_reg <= s_next;
      end
   end

   // one wait cycle: answer lands on the second edge of each request
   assign waitrequest = (read || write) && (s_reg.st == lmf_pkg::ST_IDLE);
   assign readdata = s_reg.rdata;
   assign fail_safe = s_reg.fail_safe;
   assign serial_err_summary = |s_reg.link_err; // [R13]
   assign open_fault_summary = |s_reg.per_driver_open_bits; // [R14]
   assign short_fault_summary = |s_reg.per_driver_short_bits; // [R15]
   assign irq = |(s_reg.irq_stat & s_reg.irq_mask);
endmodule

// ==== rtl/lmf_pkg.sv ====
/*
 fault status register group: offsets, field positions, reset values, carrier types.
 assumes a single 20 MHz clock domain and word-indexed register offsets.
*/
package lmf_pkg;
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 32;
   localparam int unsigned NUM_DRV = 12;
   // register indices; byte address is four times the index
   localparam logic [7:0] IDX_LINK_ERR = 8'h11;
   localparam logic [7:0] IDX_SHORT = 8'h12;
   localparam logic [7:0] IDX_OPEN = 8'h13;
   localparam logic [7:0] IDX_TOP_STAT = 8'h20;
   localparam logic [7:0] IDX_IRQ_STAT = 8'h21;
   localparam logic [7:0] IDX_IRQ_MASK = 8'h22;
   localparam logic [7:0] IDX_WDOG_CFG = 8'h23;
   localparam logic [7:0] IDX_BIT_CFG = 8'h24;
   // link error status bit positions
   localparam int unsigned BIT_START = 1;
   localparam int unsigned BIT_PL_STOP = 2;
   localparam int unsigned BIT_SYNC_STOP = 3;
   localparam int unsigned BIT_PL_PAR = 4;
   localparam int unsigned BIT_SYNC_PAR = 5;
   localparam int unsigned BIT_CRC = 6;
   localparam int unsigned BIT_TIMEOUT = 7;
   localparam int unsigned BIT_WDOG = 8;
   localparam logic [8:0] LINK_ERR_MASK = 9'h1fe;
   // top-level summary bit positions
   localparam int unsigned BIT_SHORT_SUM = 3;
   localparam int unsigned BIT_OPEN_SUM = 4;
   localparam int unsigned BIT_SERIAL_SUM = 6;
   // interrupt status layout
   localparam int unsigned IRQ_LINK = 0;
   localparam int unsigned IRQ_SHORT = 1;
   localparam int unsigned IRQ_OPEN = 2;
   localparam logic [8:0] LINK_RST = 9'h000;
   localparam logic [11:0] DRV_RST = 12'h000;
   localparam logic [2:0] IRQ_MASK_RST = 3'h0;
   // timeout: more than 16 bit times of line silence between frames
   localparam int unsigned TIMEOUT_BITS = 16;
   localparam logic [15:0] BIT_CYC_RST = 16'h00ae;
   localparam logic [23:0] WDOG_CYC_RST = 24'h030d40;

   typedef struct packed {
      logic sync_parity_fail_flag;
      logic payload_parity_fail_flag;
      logic sync_stop_fail_flag;
      logic payload_stopbit_fail_flag;
      logic payload_startbit_fail_flag;
      logic crc_fail_flag;
   } lmf_rx_err_t;

   typedef struct packed {
      logic read;
      logic write;
      logic [ADDR_W-1:0] address;
      logic [DATA_W-1:0] writedata;
   } lmf_av_req_t;

   typedef enum logic [1:0] {ST_IDLE, ST_ANSWER} lmf_bus_st_t;
endpackage

// ==== sim/lmf_fault_regs_props.sv ====
/*
 checker for the fault status bank, bound to lmf_fault_regs.
 assumes one clk domain with the async active-low rstn.
*/
`timescale 1ns/100ps
module lmf_fault_regs_props (
   input wire logic clk,
   input wire logic rstn,
   input wire logic [7:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] readdata,
   input wire logic waitrequest,
   input wire logic rx_line,
   input wire lmf_pkg::lmf_rx_err_t rx_err,
   input wire logic [11:0] short_detect,
   input wire logic [11:0] open_detect,
   input wire logic fail_safe,
   input wire logic short_fault_summary,
   input wire logic open_fault_summary,
   input wire logic serial_err_summary
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstn);
   logic clr_s;
   logic clr_o;
   // a flag may only drop on a write that completes at this edge
   assign clr_s = write && !waitrequest && address == lmf_pkg::IDX_SHORT;
   assign clr_o = write && !waitrequest && address == lmf_pkg::IDX_OPEN;
   chk_one_wait: assert property ((read || write) && waitrequest |=> !waitrequest)
      else $error("waitrequest high for more than one cycle");
   chk_serial_set: assert property ((|rx_err) |=> serial_err_summary)
      else $error("serial summary not set after receive error");
   chk_short_set: assert property ((|short_detect) |=> short_fault_summary)
      else $error("short summary not set after detect");
   chk_open_set: assert property ((|open_detect) |=> open_fault_summary)
      else $error("open summary not set after detect");
   chk_short_keep: assert property (short_fault_summary && !clr_s |=> short_fault_summary)
      else $error("short flags dropped without a write");
   chk_open_keep: assert property (open_fault_summary && !clr_o |=> open_fault_summary)
      else $error("open flags dropped without a write");
   chk_fs_cause: assert property ($rose(fail_safe) |-> serial_err_summary)
      else $error("fail safe without timeout flag");
   chk_fs_release: assert property (fail_safe && $changed(rx_line) |-> ##[1:3] !fail_safe)
      else $error("fail safe kept after line activity");
   chk_read_hold: assert property (read && !waitrequest |=> $stable(readdata))
      else $error("read data moved after the read");
   cover property (clr_s);
   cover property ($rose(fail_safe));
   cover property ((|rx_err) ##1 serial_err_summary);
endmodule
bind lmf_fault_regs lmf_fault_regs_props i_lmf_fault_regs_props (.clk(clk), .rstn(rstn), .address(address),
   .read(read), .write(write), .readdata(readdata), .waitrequest(waitrequest), .rx_line(rx_line),
   .rx_err(rx_err), .short_detect(short_detect), .open_detect(open_detect), .fail_safe(fail_safe),
   .short_fault_summary(short_fault_summary), .open_fault_summary(open_fault_summary),
   .serial_err_summary(serial_err_summary));

// ==== sim/lmf_fault_regs_test.sv ====
/*
 self-checking bench for lmf_fault_regs, with a flag model kept in logic vectors.
 assumes a 20 MHz clk and a shortened watchdog count.
*/
`timescale 1ns/100ps
module lmf_fault_regs_test;
   logic clk, rstn, read, write, waitrequest, rx_line, rx_in_frame, active, fail_safe, irq, ss, os, es;
   logic [7:0] address;
   logic [31:0] writedata, readdata, q, c;
   lmf_pkg::lmf_rx_err_t rx_err;
   logic [11:0] short_detect, open_detect, m_s, m_o;
   logic [2:0] m_i;
   int fail_count = 0, tests_run = 0, i, seed = 32'h18016055;
   int map[6] = '{6, 1, 2, 3, 4, 5};
   always #25 clk = !clk;
   lmf_host_line i_lmf_host_line (.clk(clk), .active(active), .rx_line(rx_line), .rx_in_frame(rx_in_frame));
   lmf_fault_regs #(.WDOG_CYC(24'h000032)) i_lmf_fault_regs (.clk(clk), .rstn(rstn), .address(address),
      .read(read), .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
      .rx_line(rx_line), .rx_in_frame(rx_in_frame), .rx_err(rx_err), .short_detect(short_detect),
      .open_detect(open_detect), .fail_safe(fail_safe), .short_fault_summary(ss),
      .open_fault_summary(os), .serial_err_summary(es), .irq(irq));
   task automatic finish_test;
      if (fail_count == 0 && tests_run > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
      end
   endtask
   // raises the request after an edge, holds it to the edge at which waitrequest is low, then releases
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      logic done;
      done = 1'b0;
      @(posedge clk);
      read <= !w;
      write <= w;
      address <= a;
      writedata <= d;
      // waitrequest and readdata are settled by the falling edge and stand at the next rising edge
      for (k = 0; k < 20 && !done; k++) begin
         @(negedge clk);
         done = (waitrequest === 1'b0);
         q = readdata;
         @(posedge clk);
      end
      read <= 1'b0;
      write <= 1'b0;
      if (done) begin
         @(negedge clk);
      end else begin
         check("bus timeout", 0, 1);
         finish_test();
      end
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      bus(0, a, 0);
      check($sformatf("reg %h", a), q, e);
   endtask
   task automatic pulse(input logic [5:0] e, input logic [11:0] s, input logic [11:0] o);
      @(posedge clk);
      rx_err <= lmf_pkg::lmf_rx_err_t'(e);
      short_detect <= s;
      open_detect <= o;
      @(posedge clk);
      rx_err <= '0;
      short_detect <= '0;
      open_detect <= '0;
      @(negedge clk);
   endtask
   initial begin
      {clk, rstn, read, write, address, writedata, rx_err, short_detect, open_detect, m_s, m_o} = '0;
      m_i = '0;
      active = 1;
      repeat (3) @(posedge clk);
      rstn <= 1;
      repeat (3) @(posedge clk);
      rd(lmf_pkg::IDX_SHORT, 0);
      rd(lmf_pkg::IDX_OPEN, 0);
      bus(1, lmf_pkg::IDX_IRQ_MASK, 32'h7);
      for (i = 0; i < 6; i++) begin
         pulse(6'h1 << i, 0, 0);
         check("serial_sum", es, 1);
         rd(lmf_pkg::IDX_LINK_ERR, 32'h1 << map[i]);
         bus(1, lmf_pkg::IDX_LINK_ERR, 32'h1fe);
         check("serial_sum clear", es, 0);
         check("irq", irq, 1);
         rd(lmf_pkg::IDX_IRQ_STAT, 32'h1);
         check("irq", irq, 0);
      end
      for (i = 0; i < 8; i++) begin
         c = $random(seed);
         pulse(0, c[11:0], c[27:16]);
         m_s |= c[11:0];
         m_o |= c[27:16];
         m_i |= {|c[27:16], |c[11:0], 1'b0};
         check("short_sum", ss, |m_s);
         check("open_sum", os, |m_o);
         rd(lmf_pkg::IDX_SHORT, m_s);
         c = $random(seed);
         bus(1, lmf_pkg::IDX_SHORT, c);
         m_s &= ~c[11:0];
         rd(lmf_pkg::IDX_SHORT, m_s);
         bus(1, lmf_pkg::IDX_OPEN, ~c);
         m_o &= c[11:0];
         rd(lmf_pkg::IDX_OPEN, m_o);
      end
      bus(1, lmf_pkg::IDX_IRQ_MASK, 0);
      rd(lmf_pkg::IDX_IRQ_STAT, {29'h0, m_i});
      pulse(0, 12'h800, 0);
      check("irq masked", irq, 0);
      rd(8'h30, 0);
      active = 0;
      for (i = 0; i < 4000 && fail_safe !== 1'b1; i++)
         @(negedge clk);
      check("fail_safe set", fail_safe, 1);
      rd(lmf_pkg::IDX_LINK_ERR, 32'h180);
      active = 1;
      repeat (40) @(negedge clk);
      check("fail_safe", fail_safe, 0);
      // reset in mid-run must drop the latched short and link error flags
      @(posedge clk);
      rstn <= 1'b0;
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      repeat (3) @(posedge clk);
      rd(lmf_pkg::IDX_SHORT, 0);
      rd(lmf_pkg::IDX_LINK_ERR, 0);
      finish_test();
   end
endmodule

// ==== sim/lmf_host_line.sv ====
/*
 serial host seen from the receive pin: frames of toggling bits, short idle gaps.
 assumes a line idling high; when not active it stays idle for the timeout tests.
*/
`timescale 1ns/100ps
module lmf_host_line (
   input wire logic clk,
   input wire logic active,
   output logic rx_line,
   output logic rx_in_frame
);
   int n = 0;
   // gaps stay far below sixteen bit times so no timeout fires by accident
   always @(posedge clk) begin
      n <= (n == 23) ? 0 : n + 1;
      rx_in_frame <= active && n < 20;
      rx_line <= !(active && n < 20 && n[1]);
   end
endmodule
